//--- rre_pkg.sv
// Package: encodings, phases and carrier types for the return and rotate executor
package rre_pkg;
	localparam logic [7:0] RET_LIT_OPC = 8'hb6;
	localparam logic [15:0] RET_SUB_OPC = 16'h0002;
	localparam logic [6:0] RLC_OPC = 7'h0d;
	localparam logic [6:0] RLN_OPC = 7'h11;
	localparam logic [6:0] RRC_OPC = 7'h0c;
	localparam logic [6:0] RRN_OPC = 7'h10;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] WORKING_REGISTER_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam int RET_CYCLES = 2;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_RET_LIT = 3'b001,
		OP_RET_SUB = 3'b010,
		OP_RLC = 3'b011,
		OP_RLN = 3'b100,
		OP_RRC = 3'b101,
		OP_RRN = 3'b110
	} rre_op_t;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} rre_phase_t;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} rre_file_wr_t;
endpackage

//--- rre_exec.sv
// Executor for literal return, subroutine return and four byte rotates
`timescale 1ns/1ns
`default_nettype none
module rre_exec
	import rre_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] instrWord,
	input wire logic [15:0] stackTopEntry,
	input wire logic [7:0] fileRdData,
	input wire logic [7:0] pcHighHoldingLatchIn,
	output logic [1:0] phase,
	output logic [15:0] progCounter,
	output logic stackPop,
	output logic [7:0] fileRdAddr,
	output rre_file_wr_t fileWr,
	output logic [7:0] workingRegister,
	output logic carryFlag,
	output logic flushPrefetch,
	output logic [7:0] pcHighHoldingLatch
);

	// =====================================================
	// Decode
	function automatic rre_op_t decodeOp(input logic [15:0] w);
		rre_op_t op;
		op = OP_NONE;
		if (w[15:8] == RET_LIT_OPC) begin
			op = OP_RET_LIT;
		end else if (w == RET_SUB_OPC) begin
			op = OP_RET_SUB;
		end else if (w[15:9] == RLC_OPC) begin
			op = OP_RLC;
		end else if (w[15:9] == RLN_OPC) begin
			op = OP_RLN;
		end else if (w[15:9] == RRC_OPC) begin
			op = OP_RRC;
		end else if (w[15:9] == RRN_OPC) begin
			op = OP_RRN;
		end
		return op;
	endfunction

	rre_phase_t phase_reg;
	rre_op_t op_reg;
	logic [7:0] operand_reg;
	logic destFile_reg;
	logic idleCycle_reg;
	logic idleNow_reg;
	logic [7:0] srcByte_reg;
	logic [7:0] result_reg;
	logic carryOut_reg;
	logic [15:0] pc_reg;
	logic stackPop_reg;
	logic [7:0] rdAddr_reg;
	rre_file_wr_t fileWr_reg;
	logic [7:0] working_register_reg;
	logic carry_reg;
	logic flush_reg;
	logic [7:0] latch_reg;
	logic [7:0] result_next;
	logic carry_next;

	// =====================================================
	// Phase counter, four phases per instruction cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			phase_reg <= PH_Q1;
		end else begin
			case (phase_reg)
				PH_Q1: phase_reg <= PH_Q2;
				PH_Q2: phase_reg <= PH_Q3;
				PH_Q3: phase_reg <= PH_Q4;
				PH_Q4: phase_reg <= PH_Q1;
				default: phase_reg <= PH_Q1;
			endcase
		end
	end

	// =====================================================
	// Q1 decode; the cycle after a return is forced idle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			op_reg <= OP_NONE;
			operand_reg <= 8'h00;
			destFile_reg <= 1'b0;
			idleCycle_reg <= 1'b0;
			idleNow_reg <= 1'b0;
		end else if (phase_reg == PH_Q1) begin
			operand_reg <= instrWord[7:0];
			destFile_reg <= instrWord[8];
			// Pending flag clears at Q1, so the idle cycle itself needs its own marker
			idleNow_reg <= idleCycle_reg;
			if (idleCycle_reg) begin
				op_reg <= OP_NONE;
				idleCycle_reg <= 1'b0;
			end else begin
				op_reg <= decodeOp(instrWord);
				idleCycle_reg <= (decodeOp(instrWord) == OP_RET_LIT) ||
					(decodeOp(instrWord) == OP_RET_SUB);
			end
		end
	end

	// =====================================================
	// Q2 read source byte
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdAddr_reg <= 8'h00;
			srcByte_reg <= 8'h00;
		end else begin
			if (phase_reg == PH_Q1) begin
				rdAddr_reg <= instrWord[7:0];
			end
			if (phase_reg == PH_Q2) begin
				srcByte_reg <= fileRdData;
			end
		end
	end

	// =====================================================
	// Q3 process
	always_comb begin
		result_next = srcByte_reg;
		carry_next = carry_reg;
		case (op_reg)
			OP_RLC: begin
				result_next = {srcByte_reg[6:0], carry_reg};
				carry_next = srcByte_reg[7];
			end
			OP_RLN: result_next = {srcByte_reg[6:0], srcByte_reg[7]};
			OP_RRC: begin
				result_next = {carry_reg, srcByte_reg[7:1]};
				carry_next = srcByte_reg[0];
			end
			OP_RRN: result_next = {srcByte_reg[0], srcByte_reg[7:1]};
			OP_RET_LIT: result_next = operand_reg;
			default: result_next = srcByte_reg;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			result_reg <= 8'h00;
			carryOut_reg <= CARRY_RESET;
		end else if (phase_reg == PH_Q3) begin
			result_reg <= result_next;
			carryOut_reg <= carry_next;
		end
	end

	// =====================================================
	// Q4 write destination, pop stack
	wire isRotate = (op_reg == OP_RLC) || (op_reg == OP_RLN) ||
		(op_reg == OP_RRC) || (op_reg == OP_RRN);
	wire isReturn = (op_reg == OP_RET_LIT) || (op_reg == OP_RET_SUB);
	wire atQ4 = (phase_reg == PH_Q4);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			working_register_reg <= WORKING_REGISTER_RESET;
			fileWr_reg <= '0;
		end else begin
			fileWr_reg.we <= 1'b0;
			if (atQ4 && isRotate && destFile_reg) begin
				fileWr_reg.we <= 1'b1;
				fileWr_reg.addr <= operand_reg;
				fileWr_reg.data <= result_reg;
			end else if (atQ4 && isRotate) begin
				working_register_reg <= result_reg;
			end else if (atQ4 && op_reg == OP_RET_LIT) begin
				working_register_reg <= result_reg;
			end
		end
	end

	// Only the carrying rotates touch carry; returns leave flags alone
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			carry_reg <= CARRY_RESET;
		end else if (atQ4 && (op_reg == OP_RLC || op_reg == OP_RRC)) begin
			carry_reg <= carryOut_reg;
		end
	end

	// Normal sequencing advances once per cycle; returns reload from stack top
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pc_reg <= PC_RESET;
			stackPop_reg <= 1'b0;
			flush_reg <= 1'b0;
		end else begin
			stackPop_reg <= atQ4 && isReturn;
			flush_reg <= atQ4 && isReturn;
			if (atQ4 && isReturn) begin
				pc_reg <= stackTopEntry;
			end else if (atQ4 && !idleNow_reg) begin
				pc_reg <= pc_reg + 16'h0001;
			end
		end
	end

	// Latch follows its own writer only; returns never load it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			latch_reg <= 8'h00;
		end else begin
			latch_reg <= pcHighHoldingLatchIn;
		end
	end

	assign phase = phase_reg;
	assign progCounter = pc_reg;
	assign stackPop = stackPop_reg;
	assign fileRdAddr = rdAddr_reg;
	assign fileWr = fileWr_reg;
	assign workingRegister = working_register_reg;
	assign carryFlag = carry_reg;
	assign flushPrefetch = flush_reg;
	assign pcHighHoldingLatch = latch_reg;

endmodule
`default_nettype wire

//--- rre_exec_sva.sv
// Checker for the return and rotate executor
`timescale 1ns/1ns
`default_nettype none
module rre_exec_sva
	import rre_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] stackTopEntry,
	input wire logic [7:0] pcHighHoldingLatchIn,
	input wire logic [1:0] phase,
	input wire logic [15:0] progCounter,
	input wire logic stackPop,
	input wire rre_file_wr_t fileWr,
	input wire logic [7:0] workingRegister,
	input wire logic flushPrefetch,
	input wire logic [7:0] pcHighHoldingLatch
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// Return idle cycle
	sequence quiet4;
		(!stackPop && !fileWr.we && $stable(progCounter)) [*4];
	endsequence
	pop_idle_a: assert property (stackPop |=> quiet4) else $error("idle cycle acted");
	pop_flush_a: assert property (stackPop == flushPrefetch) else $error("flush mismatch");
	pop_pc_a: assert property (stackPop |-> progCounter == $past(stackTopEntry)) else $error("bad pc");
	latch_copy_a: assert property ($past(rst_n) |-> pcHighHoldingLatch == $past(pcHighHoldingLatchIn))
		else $error("latch altered");
	phase_step_a: assert property ($past(rst_n) |-> phase == 2'($past(phase) + 2'h1))
		else $error("phase skip");
	wr_pulse_a: assert property (fileWr.we |-> phase == 2'h0 ##1 !fileWr.we) else $error("bad write");
	working_register_edge_a: assert property ($past(rst_n) && $changed(workingRegister) |-> phase == 2'h0)
		else $error("working_register early");
	pc_edge_a: assert property ($past(rst_n) && $changed(progCounter) |-> phase == 2'h0)
		else $error("pc early");
endmodule
bind rre_exec rre_exec_sva chk(.ref_clk(ref_clk), .rst_n(rst_n), .stackTopEntry(stackTopEntry),
	.pcHighHoldingLatchIn(pcHighHoldingLatchIn), .phase(phase), .progCounter(progCounter), .stackPop(stackPop),
	.fileWr(fileWr), .workingRegister(workingRegister), .flushPrefetch(flushPrefetch),
	.pcHighHoldingLatch(pcHighHoldingLatch));
`default_nettype wire

//--- return_and_rotate_exec_test.sv
// Testbench for the return and rotate executor
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec_test;
	import rre_pkg::*;
	logic ref_clk = 0, rst_n = 0, stackPop, carryFlag, flushPrefetch, c;
	logic [15:0] instrWord = 0, stackTopEntry = 0, progCounter, pc;
	logic [7:0] fileRdData = 0, pcHighHoldingLatchIn = 0, fileRdAddr, workingRegister, pcHighHoldingLatch, w;
	logic [1:0] phase;
	rre_file_wr_t fileWr;
	logic [6:0] ops [4] = '{RLC_OPC, RLN_OPC, RRC_OPC, RRN_OPC};
	int seed = 38, failures = 0, comparisons = 0, cycles = 0;
	rre_exec DUT(.ref_clk(ref_clk), .rst_n(rst_n), .instrWord(instrWord), .stackTopEntry(stackTopEntry),
		.fileRdData(fileRdData), .pcHighHoldingLatchIn(pcHighHoldingLatchIn), .phase(phase),
		.progCounter(progCounter), .stackPop(stackPop), .fileRdAddr(fileRdAddr), .fileWr(fileWr),
		.workingRegister(workingRegister), .carryFlag(carryFlag), .flushPrefetch(flushPrefetch),
		.pcHighHoldingLatch(pcHighHoldingLatch));
	initial forever #2 ref_clk = ~ref_clk;
	// ==========
	// Checking and expectations
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [8:0] rot(input logic [6:0] o, input logic [7:0] b, input logic ci);
		case (o)
			RLC_OPC: rot = {b[7], b[6:0], ci};
			RLN_OPC: rot = {ci, b[6:0], b[7]};
			RRC_OPC: rot = {b[0], ci, b[7:1]};
			default: rot = {ci, b[0], b[7:1]};
		endcase
	endfunction
	// One instruction is four clocks, always stepped from phase zero
	task automatic tick(input logic [15:0] iw);
		instrWord = iw;
		pcHighHoldingLatchIn = 8'($random(seed));
		repeat (4) @(posedge ref_clk);
		#1;
		cmp("working_register", 16'(w), 16'(workingRegister));
		cmp("carry", 16'(c), 16'(carryFlag));
		cmp("pc", pc, progCounter);
		cmp("latch", 16'(pcHighHoldingLatchIn), 16'(pcHighHoldingLatch));
		cmp("rdaddr", 16'(iw[7:0]), 16'(fileRdAddr));
	endtask
	task automatic rt(input logic [6:0] o, input logic d, input logic [7:0] b);
		logic [8:0] r;
		logic [7:0] a;
		r = rot(o, b, c);
		a = 8'($random(seed));
		fileRdData = b;
		pc = pc + 16'h1;
		c = r[8];
		if (!d)
			w = r[7:0];
		tick({o, d, a});
		cmp("we", 16'(d), 16'(fileWr.we));
		if (d)
			cmp("wdata", {a, r[7:0]}, {fileWr.addr, fileWr.data});
	endtask
	task automatic ret(input logic lit, input logic [7:0] k);
		stackTopEntry = 16'($random(seed));
		pc = stackTopEntry;
		if (lit)
			w = k;
		tick(lit ? {RET_LIT_OPC, k} : RET_SUB_OPC);
		cmp("pop", 16'h1, 16'(stackPop));
		tick({RLC_OPC, 1'b1, k});
		cmp("idle we", 16'h0, 16'(fileWr.we));
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 3000) begin
			failures++;
			give_verdict;
		end
	end
	initial begin
		pc = PC_RESET;
		w = WORKING_REGISTER_RESET;
		c = CARRY_RESET;
		repeat (16) @(posedge ref_clk);
		#1;
		rst_n = 1;
		cmp("phase", 16'(PHASE_RESET), 16'(phase));
		for (int i = 0; i < 48; i++)
			rt(ops[i % 4], i[2], i < 16 ? (i[3] ? 8'h80 : 8'h01) : 8'($random(seed)));
		for (int j = 0; j < 6; j++) begin
			ret(j[0], 8'($random(seed)));
			rt(ops[j % 4], 1'b0, 8'($random(seed)));
		end
		give_verdict;
	end
endmodule
`default_nettype wire
